// ===== hdl/rbs_pkg.sv
package rbs_pkg;

  // sequencer clock rate and derived timing
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned IRC_HZ          = 4_000_000;
  // clocks per internal-oscillator cycle
  localparam int unsigned IRC_DIV         = CLK_HZ / IRC_HZ;
  // fixed wake-up count after any reset, in oscillator cycles
  localparam int unsigned WAKE_CYCLES     = 16;
  // flash start-up time, in nanoseconds, and its oscillator-cycle count
  localparam int unsigned FLASH_START_NS  = 100_000;
  localparam int unsigned FLASH_CYCLES    =
    (FLASH_START_NS * (IRC_HZ / 1_000_000) + 999) / 1000;
  // sleep resume counts
  localparam int unsigned SLEEP_IRC_CYC   = 4;
  localparam int unsigned SLEEP_EXT_CYC   = 4096;
  // supply thresholds in millivolts, with hysteresis band
  localparam logic [11:0] LV_IRQ_MV       = 12'hb86;  // 2950
  localparam logic [11:0] LV_RST_MV       = 12'ha5a;  // 2650
  localparam logic [11:0] POR_MV          = 12'h3e8;  // 1000
  localparam logic [11:0] HYST_MV         = 12'h032;  // 50
  // boot fetch address after release
  localparam logic [31:0] BOOT_ADDR       = 32'h0000_0000;
  // counter width
  localparam int unsigned CNT_W           = 13;

  // sequencer states
  typedef enum logic [2:0]
  {
    RBS_HOLD  = 3'b000,
    RBS_WAKE  = 3'b001,
    RBS_FLASH = 3'b010,
    RBS_RUN   = 3'b011,
    RBS_SLEEP = 3'b100,
    RBS_DEEP  = 3'b101,
    RBS_RESUME = 3'b110
  } rbs_state_t;

endpackage

// ===== hdl/rbs_sync_if.sv
`timescale 1ns/1ns
// raw and synchronised event lines between top and synchroniser
interface rbs_sync_if;
  logic [5:0] raw;   // asynchronous inputs
  logic [5:0] sync;  // clean copies
  modport src (output raw, input sync);
  modport dst (input raw, output sync);
endinterface

// ===== hdl/rbs_sync.sv
`timescale 1ns/1ns
// two-flop synchroniser bank, one per line
module rbs_sync
  import rbs_pkg::*;
(
  input  wire logic i_mclk,  // sequencer clock
  input  wire logic i_srst,  // sync reset
  rbs_sync_if.dst   s        // raw in, clean out
);

  logic [5:0] meta_q;  // first stage, read only by second
  logic [5:0] meta_d;
  logic [5:0] sync_q;  // second stage
  logic [5:0] sync_d;

  // next values
  always_comb
  begin
    meta_d = s.raw;
    sync_d = meta_q;
  end

  // registers
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      meta_q <= 6'h00;
      sync_q <= 6'h00;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign s.sync = sync_q;

endmodule

// ===== hdl/rbs_cmp.sv
`timescale 1ns/1ns
// threshold comparator with hysteresis
module rbs_cmp
  import rbs_pkg::*;
(
  input  wire logic        i_mclk,  // sequencer clock
  input  wire logic        i_srst,  // sync reset
  input  wire logic [11:0] i_mv,    // supply in millivolts
  input  wire logic [11:0] i_thr,   // falling threshold
  output logic             o_low    // below threshold, held
);

  logic low_q;  // indication
  logic low_d;

  // set below threshold, clear only at or above threshold plus band;
  // the band stops chatter near the trip point
  always_comb
  begin
    low_d = low_q;
    if (i_mv < i_thr)
      low_d = 1'b1;
    else if (i_mv >= 12'(i_thr + HYST_MV))
      low_d = 1'b0;
  end

  // register; start low after reset, supply unknown
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      low_q <= 1'b1;
    else
      low_q <= low_d;
  end

  assign o_low = low_q;

endmodule

// ===== hdl/rbs_seq.sv
`timescale 1ns/1ns
// Notes on behaviour
// - four causes merge into one internal reset
// - release needs pin, oscillator, count, flash
// - core fetches from address zero after release
// - registers hold reset values at release
// - low-voltage request below upper threshold
// - request gated by enable, level pollable
// - lower threshold forces chip reset
// - brownout holds reset; power-on below lowest
// - both thresholds have hysteresis
// - battery domain only clock, RAM; alarm
// - wake-ups run from internal oscillator
// - flash wake-up counts oscillator cycles
// - sleep resume: short or long count
// - deep power-down wakes on alarm, reset
module rbs_seq
  import rbs_pkg::*;
(
  input  wire logic        i_mclk,       // sequencer clock
  input  wire logic        i_srst,       // sync reset, active high
  input  wire logic        i_pin_rst_n,  // external reset pin, low
  input  wire logic        i_wdt_rst,    // watchdog timeout
  input  wire logic        i_por,        // power-on detect
  input  wire logic        i_osc_run,    // oscillator running
  input  wire logic        i_flash_done, // flash init complete
  input  wire logic        i_rtc_alarm,  // battery-domain alarm
  input  wire logic [11:0] i_supply_mv,  // core supply, millivolts
  input  wire logic        i_irq_en,     // low-voltage enable
  input  wire logic        i_sleep_req,  // enter sleep
  input  wire logic        i_deep_req,   // enter deep power-down
  input  wire logic        i_wake_irq,   // wake interrupt in sleep
  input  wire logic        i_ext_clk,    // ext osc was source
  output logic             o_rst,        // internal reset
  output logic             o_core_run,   // core may execute
  output logic [31:0]      o_fetch_addr, // first fetch address
  output logic             o_lv_irq,     // request to controller
  output logic             o_lv_status,  // pollable level
  output logic             o_flash_ok,   // flash access granted
  output logic             o_use_irc,    // clock from oscillator
  output logic             o_alarm_out   // wakes external supply
);

  //////////////////////////////////////////////////////////////////////////
  // synchronisers and comparators

  rbs_sync_if sif ();  // raw to clean lines

  // asynchronous causes and flags enter the clock domain here
  assign sif.raw = {i_rtc_alarm, i_flash_done, i_osc_run,
                    i_por, i_wdt_rst, ~i_pin_rst_n};

  rbs_sync u_sync
  (
    .i_mclk (i_mclk),
    .i_srst (i_srst),
    .s      (sif)
  );

  logic pin_s;    // pin asserted
  logic wdt_s;    // watchdog
  logic por_s;    // power-on
  logic osc_s;    // oscillator running
  logic fdone_s;  // flash init done
  logic alarm_s;  // alarm
  assign {alarm_s, fdone_s, osc_s, por_s, wdt_s, pin_s} = sif.sync;

  logic lv_irq_w;  // first stage low
  logic lv_rst_w;  // second stage low
  logic por_lv_w;  // below lowest level

  rbs_cmp u_cmp_irq
  (
    .i_mclk (i_mclk),
    .i_srst (i_srst),
    .i_mv   (i_supply_mv),
    .i_thr  (LV_IRQ_MV),
    .o_low  (lv_irq_w)
  );

  rbs_cmp u_cmp_rst
  (
    .i_mclk (i_mclk),
    .i_srst (i_srst),
    .i_mv   (i_supply_mv),
    .i_thr  (LV_RST_MV),
    .o_low  (lv_rst_w)
  );

  rbs_cmp u_cmp_por
  (
    .i_mclk (i_mclk),
    .i_srst (i_srst),
    .i_mv   (i_supply_mv),
    .i_thr  (POR_MV),
    .o_low  (por_lv_w)
  );

  //////////////////////////////////////////////////////////////////////////
  // reset cause merge

  logic cause_w;  // any reset cause active
  // brownout covers down to the lowest level, power-on below it;
  // both are ored so there is no gap at the hand-over
  assign cause_w = pin_s | wdt_s | por_s | lv_rst_w | por_lv_w;

  //////////////////////////////////////////////////////////////////////////
  // oscillator tick divider

  logic [2:0] div_q;  // prescaler
  logic [2:0] div_d;
  logic       tick_w; // one oscillator cycle
  logic       div_clr_w; // restart phase while held

  assign tick_w = (div_q == 3'(IRC_DIV - 1));

  // divider restarts while held, so the first counted tick after
  // release is a whole oscillator cycle and the wake count is never short
  always_comb
  begin
    div_d = (tick_w || div_clr_w) ? 3'h0 : 3'(div_q + 3'h1);
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      div_q <= 3'h0;
    else
      div_q <= div_d;
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer

  rbs_state_t       st_q;     // state
  rbs_state_t       st_d;
  logic [CNT_W-1:0] cnt_q;    // oscillator-cycle counter
  logic [CNT_W-1:0] cnt_d;
  logic             rel_q;    // release request, stage one
  logic             rel_d;
  logic             rst_q;    // internal reset output
  logic             rst_d;
  logic             run_q;    // core run
  logic             run_d;
  logic             fok_q;    // flash grant
  logic             fok_d;
  logic             irc_q;    // clock source is oscillator
  logic             irc_d;
  logic             ext_q;    // ext source remembered at sleep
  logic             ext_d;
  logic             lvi_q;    // gated request
  logic             lvi_d;
  logic             lvs_q;    // status level
  logic             lvs_d;
  logic             alm_q;    // alarm out
  logic             alm_d;

  // the oscillator divider is held at phase zero in HOLD
  assign div_clr_w = (st_q == RBS_HOLD);

  // next-state logic
  always_comb
  begin
    st_d  = st_q;
    cnt_d = cnt_q;
    fok_d = fok_q;
    irc_d = irc_q;
    ext_d = ext_q;
    run_d = 1'b0;
    rel_d = 1'b0;
    case (st_q)
      RBS_HOLD:
      begin
        irc_d = 1'b1;
        fok_d = 1'b0;
        cnt_d = '0;
        // wake timer starts once causes have gone and the oscillator runs
        if (!cause_w && osc_s)
          st_d = RBS_WAKE;
      end
      RBS_WAKE:
      begin
        if (tick_w)
          cnt_d = CNT_W'(cnt_q + 1'b1);
        if (cnt_q >= CNT_W'(WAKE_CYCLES) && fdone_s)
        begin
          st_d  = RBS_FLASH;
          cnt_d = '0;
        end
      end
      RBS_FLASH:
      begin
        if (tick_w)
          cnt_d = CNT_W'(cnt_q + 1'b1);
        if (cnt_q >= CNT_W'(FLASH_CYCLES))
        begin
          fok_d = 1'b1;
          st_d  = RBS_RUN;
        end
      end
      RBS_RUN:
      begin
        rel_d = 1'b1;
        run_d = rst_q ? 1'b0 : 1'b1;
        if (i_deep_req)
          st_d = RBS_DEEP;
        else if (i_sleep_req)
        begin
          ext_d = i_ext_clk;
          st_d  = RBS_SLEEP;
        end
      end
      RBS_SLEEP:
      begin
        rel_d = 1'b1;
        cnt_d = '0;
        if (i_wake_irq)
          st_d = RBS_RESUME;
      end
      RBS_RESUME:
      begin
        rel_d = 1'b1;
        if (tick_w)
          cnt_d = CNT_W'(cnt_q + 1'b1);
        // long count for crystal, short for internal oscillator
        if (cnt_q >= (ext_q ? CNT_W'(SLEEP_EXT_CYC)
                            : CNT_W'(SLEEP_IRC_CYC)))
          st_d = RBS_RUN;
      end
      RBS_DEEP:
      begin
        rel_d = 1'b1;
        // only alarm or a reset cause (pin, watchdog, power-on, brownout) wake it, and wake is a full reset
        if (alarm_s)
          st_d = RBS_HOLD;
      end
      default:
        st_d = RBS_HOLD;
    endcase
    // any cause restarts the whole sequence, pin included
    if (cause_w)
    begin
      st_d  = RBS_HOLD;
      rel_d = 1'b0;
      run_d = 1'b0;
      fok_d = 1'b0;
    end
  end

  // assert at once on a cause, release two flops after request
  always_comb
  begin
    rst_d = cause_w ? 1'b1 : ~rel_q;
  end

  // low-voltage request, gated by the controller enable
  always_comb
  begin
    lvs_d = lv_irq_w;
    lvi_d = lv_irq_w & i_irq_en;
    alm_d = alarm_s;
  end

  // state registers; reset values are defined before release
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      st_q  <= RBS_HOLD;
      cnt_q <= '0;
      rel_q <= 1'b0;
      rst_q <= 1'b1;
      run_q <= 1'b0;
      fok_q <= 1'b0;
      irc_q <= 1'b1;
      ext_q <= 1'b0;
      lvi_q <= 1'b0;
      lvs_q <= 1'b0;
      alm_q <= 1'b0;
    end
    else
    begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      rel_q <= rel_d;
      rst_q <= rst_d;
      run_q <= run_d;
      fok_q <= fok_d;
      irc_q <= irc_d;
      ext_q <= ext_d;
      lvi_q <= lvi_d;
      lvs_q <= lvs_d;
      alm_q <= alm_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs, all from flops

  logic [31:0] fa_q;  // fetch address, fixed at boot vector
  always_ff @(posedge i_mclk)
  begin
    fa_q <= BOOT_ADDR;
  end

  assign o_rst        = rst_q;
  assign o_core_run   = run_q;
  assign o_fetch_addr = fa_q;
  assign o_lv_irq     = lvi_q;
  assign o_lv_status  = lvs_q;
  assign o_flash_ok   = fok_q;
  assign o_use_irc    = irc_q;
  assign o_alarm_out  = alm_q;

endmodule

// ===== sim/rbs_env.sv
`timescale 1ns/1ns
// rail, power-on detector, oscillator and flash beside the sequencer
module rbs_env
  import rbs_pkg::*;
(
  input  wire logic        i_mclk,       // sequencer clock
  input  wire logic        i_rst,        // internal reset seen
  input  wire logic [11:0] i_mv,         // commanded rail level
  output logic [11:0]      o_supply_mv,  // rail to the monitor
  output logic             o_por,        // power-on detect
  output logic             o_osc_run,    // oscillator running
  output logic             o_flash_done  // flash init complete
);
  logic [7:0] osc_q;  // oscillator start-up count
  logic [3:0] fl_q;   // flash init count, redone every reset
  assign o_supply_mv  = i_mv;
  // power-on detect takes over below the lowest level
  assign o_por        = (i_mv < POR_MV);
  assign o_osc_run    = &osc_q;
  assign o_flash_done = &fl_q;
  // slow start on purpose: the sequencer must wait for both
  always @(negedge i_mclk)
  begin
    osc_q <= o_por ? 8'h00 : osc_q + {7'h00, ~&osc_q};
    fl_q  <= (!i_rst || !o_osc_run) ? 4'h0 : fl_q + {3'h0, ~&fl_q};
  end
endmodule

// ===== sim/rbs_seq_props.sv
`timescale 1ns/1ns
// watches the sequencer ports only
module rbs_seq_props
  import rbs_pkg::*;
(
  input wire logic        i_mclk,       // sequencer clock
  input wire logic        i_srst,       // sync reset
  input wire logic        i_pin_rst_n,  // reset pin
  input wire logic        i_wdt_rst,    // watchdog
  input wire logic        i_por,        // power-on
  input wire logic [11:0] i_supply_mv,  // rail
  input wire logic        o_rst,        // internal reset
  input wire logic        o_core_run,   // core running
  input wire logic [31:0] o_fetch_addr, // first fetch
  input wire logic        o_lv_irq,     // request out
  input wire logic        o_lv_status,  // polled level
  input wire logic        o_flash_ok,   // flash granted
  input wire logic        o_use_irc     // clock source
);
  localparam int MIN_HOLD = (WAKE_CYCLES + FLASH_CYCLES) * IRC_DIV;
  logic [12:0] hi_q;  // cycles reset held high, saturating
  logic [12:0] hi_d;  // next count
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  // count how long reset has stood, to catch an early release
  always_comb
  begin
    hi_d = o_rst ? hi_q + {12'h000, ~&hi_q} : 13'h0000;
  end
  always_ff @(posedge i_mclk)
  begin
    hi_q <= i_srst ? 13'h0000 : hi_d;
  end
  property p_pin;
    !i_pin_rst_n |-> ##[1:5] o_rst;
  endproperty
  a_pin:
    assert property (p_pin) else $error("pin did not reset");
  property p_wdt;
    i_wdt_rst |-> ##[1:5] o_rst;
  endproperty
  a_wdt:
    assert property (p_wdt) else $error("watchdog did not reset");
  property p_por;
    i_por |-> ##[1:5] o_rst;
  endproperty
  a_por:
    assert property (p_por) else $error("power-on did not reset");
  property p_brown;
    (i_supply_mv < LV_RST_MV) |-> ##[1:6] o_rst;
  endproperty
  a_brown:
    assert property (p_brown) else $error("brownout did not reset");
  property p_lv;
    (i_supply_mv < LV_IRQ_MV) |-> ##[1:4] o_lv_status;
  endproperty
  a_lv:
    assert property (p_lv) else $error("low-voltage flag missing");
  property p_gate;
    o_lv_irq |-> o_lv_status;
  endproperty
  a_gate:
    assert property (p_gate) else $error("request without level");
  property p_hyst;
    (i_supply_mv < LV_IRQ_MV + HYST_MV)[*4] ##0 o_lv_status |=> o_lv_status;
  endproperty
  a_hyst:
    assert property (p_hyst) else $error("flag dropped inside band");
  property p_hold;
    $fell(o_rst) |-> hi_q >= MIN_HOLD && o_flash_ok && o_use_irc;
  endproperty
  a_hold:
    assert property (p_hold) else $error("reset released too early");
  property p_fetch;
    o_fetch_addr == BOOT_ADDR;
  endproperty
  a_fetch:
    assert property (p_fetch) else $error("fetch address not zero");
  property p_run;
    o_core_run |-> !o_rst && !$past(o_rst);
  endproperty
  a_run:
    assert property (p_run) else $error("core ran under reset");
  c_rel: cover property ($fell(o_rst));
  c_irq: cover property (o_lv_irq);
  c_slp: cover property ($fell(o_core_run) && !o_rst);
endmodule
bind rbs_seq rbs_seq_props u_props (.*);

// ===== sim/rbs_seq_tb.sv
`timescale 1ns/1ns
module rbs_seq_tb;
  import rbs_pkg::*;
  logic        i_mclk = 1'b0;
  logic        i_srst = 1'b1;
  logic        i_pin_rst_n = 1'b1;
  logic        i_wdt_rst = 1'b0;
  logic        i_rtc_alarm = 1'b0;
  logic        i_irq_en = 1'b0;
  logic        i_sleep_req = 1'b0;
  logic        i_deep_req = 1'b0;
  logic        i_wake_irq = 1'b0;
  logic        i_ext_clk = 1'b0;
  logic [11:0] mv = 12'h000;  // commanded rail
  logic [11:0] i_supply_mv;
  logic        i_por, i_osc_run, i_flash_done;
  logic        o_rst, o_core_run, o_lv_irq, o_lv_status;
  logic        o_flash_ok, o_use_irc, o_alarm_out;
  logic [31:0] o_fetch_addr;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          cyc = 0;
  rbs_seq u_dut (.*);
  rbs_env u_env (.i_mclk, .i_rst(o_rst), .i_mv(mv),
    .o_supply_mv(i_supply_mv), .o_por(i_por), .o_osc_run(i_osc_run),
    .o_flash_done(i_flash_done));
  initial
  begin
    forever #25 i_mclk = ~i_mclk;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // bounded wait for the core to run; returns cycles waited
  task automatic wait_run(input int lim, output int k);
    k = 0;
    while (o_core_run !== 1'b1 && k < lim)
    begin
      @(negedge i_mclk);
      k++;
    end
  endtask
  // full start-up after the last cause clears
  task automatic boot;
    int k;
    wait_run(4000, k);
    chk(o_core_run, 1'b1);
    chk(32'(k >= (WAKE_CYCLES + FLASH_CYCLES) * IRC_DIV), 1);
    chk({o_rst, o_flash_ok, o_use_irc}, 3'b011);
    chk(o_fetch_addr, BOOT_ADDR);
  endtask
  // each cause alone must pull reset and stop the core
  task automatic t_causes;
    for (int c = 0; c < 4; c++)
    begin
      i_pin_rst_n = (c != 0);
      i_wdt_rst = (c == 1);
      mv = (c == 2) ? 12'h320 : (c == 3) ? 12'ha28 : 12'hce4;
      repeat (8) @(negedge i_mclk);
      chk({o_rst, o_core_run}, 2'b10);
      i_pin_rst_n = 1'b1;
      i_wdt_rst = 1'b0;
      mv = 12'hce4;
      boot;
    end
  endtask
  // low-voltage band: flag, gated request, hysteresis, no reset
  task automatic t_lv;
    mv = 12'hb54;
    repeat (6) @(negedge i_mclk);
    chk({o_lv_status, o_lv_irq}, 2'b10);
    i_irq_en = 1'b1;
    repeat (6) @(negedge i_mclk);
    chk(o_lv_irq, 1'b1);
    mv = 12'hb90;
    repeat (6) @(negedge i_mclk);
    chk({o_lv_status, o_rst}, 2'b10);
    mv = 12'hce4;
    repeat (6) @(negedge i_mclk);
    chk({o_lv_status, o_lv_irq}, 2'b00);
    i_irq_en = 1'b0;
  endtask
  // sleep with each clock source: short and long resume counts
  task automatic t_sleep;
    int k;
    for (int e = 0; e < 2; e++)
    begin
      i_ext_clk = e[0];
      i_sleep_req = 1'b1;
      repeat (8) @(negedge i_mclk);
      chk(o_core_run, 1'b0);
      i_sleep_req = 1'b0;
      i_wake_irq = 1'b1;
      repeat ((e ? SLEEP_EXT_CYC : SLEEP_IRC_CYC) * IRC_DIV - 2)
        @(negedge i_mclk);
      chk(o_core_run, 1'b0);
      wait_run(40, k);
      chk({o_core_run, o_rst}, 2'b10);
      i_wake_irq = 1'b0;
    end
  endtask
  // deep power-down ignores sleep wake, alarm gives a full reset
  task automatic t_deep;
    i_deep_req = 1'b1;
    i_wake_irq = 1'b1;
    repeat (8) @(negedge i_mclk);
    i_deep_req = 1'b0;
    repeat (8) @(negedge i_mclk);
    chk(o_core_run, 1'b0);
    i_wake_irq = 1'b0;
    i_rtc_alarm = 1'b1;
    repeat (8) @(negedge i_mclk);
    chk({o_rst, o_alarm_out}, 2'b11);
    i_rtc_alarm = 1'b0;
    boot;
  endtask
  // the whole run needs about 34000 cycles
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      error_cnt++;
      give_verdict;
    end
  end
  initial
  begin
    repeat (4) @(negedge i_mclk);
    i_srst = 1'b0;
    mv = 12'hce4;
    boot;
    t_causes;
    t_lv;
    t_sleep;
    t_deep;
    give_verdict;
  end
endmodule
